// File: prlc_pkg.sv
// Package for the receive length error counter bank
package prlc_pkg;

  // Register offsets (16-bit word addresses within the channel)
  localparam logic [7:0] ADDR_UNDER_LOW  = 8'h6c;
  localparam logic [7:0] ADDR_UNDER_HIGH = 8'h6d;
  localparam logic [7:0] ADDR_OVER       = 8'h6e;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h6f;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h70;

  // Counter widths
  localparam int UNDER_WIDTH = 27;
  localparam int OVER_WIDTH  = 16;
  localparam int UNDER_LOW_WIDTH = 16;
  localparam int UNDER_HIGH_WIDTH = UNDER_WIDTH - UNDER_LOW_WIDTH;
  localparam int LEN_WIDTH   = 16;

  // Status bit positions
  localparam int BIT_OVER_WRAP  = 14;
  localparam int BIT_UNDER_WRAP = 13;
  localparam int BIT_BYTE_WRAP  = 12;
  localparam int BIT_FRAME_WRAP = 11;
  localparam int BIT_ABORT_WRAP = 10;
  localparam int BIT_CRC_WRAP   = 9;

  // Writable mask of the wrap flag field
  localparam logic [15:0] WRAP_MASK = 16'h7e00;
  localparam logic [15:0] ZERO16    = 16'h0000;

  // Wrap events from the sibling counters outside this block
  typedef struct packed {
    logic byte_wrap;
    logic frame_wrap;
    logic abort_wrap;
    logic crc_err_wrap;
  } prlc_ext_wrap_s;

  // One completed frame written into the receive FIFO
  typedef struct packed {
    logic                 valid;
    logic [LEN_WIDTH-1:0] length;
  } prlc_frame_s;

  // Register port request
  typedef struct packed {
    logic       cs;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } prlc_req_s;

endpackage : prlc_pkg

// File: prlc_snap.sv
// Snapshot-and-clear counter with wrap pulse
`timescale 1ns/1ps
`default_nettype none
module prlc_snap #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             inc,
  input  wire logic             snap,
  output var  logic [WIDTH-1:0] snapshot,
  output var  logic             wrap
);

  // Elaboration check; the wrap test needs at least two bits
  if (WIDTH < 2 || WIDTH > 32)
  begin : g_bad_width
    $error("prlc_snap: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] snapshot;
    logic             wrap;
  } prlc_snap_s;

  prlc_snap_s state;
  prlc_snap_s next_state;

  // Snapshot wins over counting; a frame in the snap cycle starts the new run
  always_comb
  begin
    next_state = state;
    next_state.wrap = 1'b0;
    if (snap)
    begin
      next_state.snapshot = state.count;
      next_state.count = {{(WIDTH-1){1'b0}}, inc};
    end
    else if (inc)
    begin
      next_state.count = state.count + {{(WIDTH-1){1'b0}}, 1'b1};
      next_state.wrap = &state.count;
    end
  end

  // Register the state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign snapshot = state.snapshot;
  assign wrap     = state.wrap;

endmodule : prlc_snap
`default_nettype wire

// File: prlc_top.sv
// Receive length error counters, wrap flags and register port
// Notes on behaviour
// - Count frames shorter than minimum length
// - Undersize count ignores discard enable
// - Write high address snapshots and clears undersize
// - Undersize snapshot split high 26:16, low 15:0
// - Count frames longer than maximum length
// - Oversize count ignores discard enable
// - Write oversize address snapshots and clears
// - Bit 14 sets on oversize wrap
// - Bit 13 sets on undersize wrap
// - Bit 12 sets on byte counter wrap
// - Bit 11 sets on good-frame wrap
// - Bit 10 sets on aborted-frame wrap
// - Bit 9 sets on crc error wrap
// - Status read clears bits; reset zero
// - Interrupt only where enable bit set
`timescale 1ns/1ps
`default_nettype none
module prlc_top #(
  parameter int UNDER_WIDTH = prlc_pkg::UNDER_WIDTH,
  parameter int OVER_WIDTH  = prlc_pkg::OVER_WIDTH
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire prlc_pkg::prlc_req_s        req,
  input  wire prlc_pkg::prlc_frame_s      frame,
  input  wire logic [prlc_pkg::LEN_WIDTH-1:0] min_packet_length,
  input  wire logic [prlc_pkg::LEN_WIDTH-1:0] max_packet_length,
  input  wire logic                       undersize_discard_enable,
  input  wire logic                       oversize_discard_enable,
  input  wire prlc_pkg::prlc_ext_wrap_s   ext_wrap,
  output var  logic [15:0]                rdata,
  output var  logic                       rvalid,
  output var  logic                       irq
);

  // The register split and the 16-bit port cap the widths; narrower
  // counters are zero extended so short builds still read back sanely
  if (UNDER_WIDTH < 2 || UNDER_WIDTH > prlc_pkg::UNDER_WIDTH)
  begin : g_bad_under
    $error("prlc_top: UNDER_WIDTH must lie in 2 to 27");
  end
  if (OVER_WIDTH < 2 || OVER_WIDTH > prlc_pkg::OVER_WIDTH)
  begin : g_bad_over
    $error("prlc_top: OVER_WIDTH must lie in 2 to 16");
  end

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] enable;
    logic [15:0] rdata;
    logic        rvalid;
    logic        irq;
  } prlc_top_s;

  typedef logic [prlc_pkg::UNDER_WIDTH-1:0] prlc_under_t;

  prlc_top_s state;
  prlc_top_s next_state;

  logic                   wr_hit;
  logic                   rd_hit;
  logic                   under_inc;
  logic                   over_inc;
  logic                   under_snap;
  logic                   over_snap;
  logic [UNDER_WIDTH-1:0] under_snapshot;
  prlc_under_t            under_wide;
  logic [OVER_WIDTH-1:0]  over_snapshot;
  logic                   under_wrap;
  logic                   over_wrap;
  logic [15:0]            wrap_set;
  logic                   unused_discard;

  // Qualified register port strobes
  assign wr_hit = req.cs & req.wr;
  assign rd_hit = req.cs & req.rd;

  // Discard enables are left unused here and never touch the counts
  assign unused_discard = undersize_discard_enable ^ oversize_discard_enable;

  // Length comparisons on each completed frame
  assign under_inc = frame.valid & (frame.length < min_packet_length);
  assign over_inc  = frame.valid & (frame.length > max_packet_length);

  // Snapshot strobes
  assign under_snap = wr_hit & (req.addr == prlc_pkg::ADDR_UNDER_HIGH);
  assign over_snap  = wr_hit & (req.addr == prlc_pkg::ADDR_OVER);

  // Undersize counter
  prlc_snap #(
    .WIDTH    (UNDER_WIDTH)
  ) u_under (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inc      (under_inc),
    .snap     (under_snap),
    .snapshot (under_snapshot),
    .wrap     (under_wrap)
  );

  // Oversize counter
  prlc_snap #(
    .WIDTH    (OVER_WIDTH)
  ) u_over (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inc      (over_inc),
    .snap     (over_snap),
    .snapshot (over_snapshot),
    .wrap     (over_wrap)
  );

  // Snapshot widened to the full register split
  assign under_wide = prlc_under_t'(under_snapshot);

  // Gather wrap pulses into their status positions
  always_comb
  begin
    wrap_set = prlc_pkg::ZERO16;
    wrap_set[prlc_pkg::BIT_OVER_WRAP]  = over_wrap;
    wrap_set[prlc_pkg::BIT_UNDER_WRAP] = under_wrap;
    wrap_set[prlc_pkg::BIT_BYTE_WRAP]  = ext_wrap.byte_wrap;
    wrap_set[prlc_pkg::BIT_FRAME_WRAP] = ext_wrap.frame_wrap;
    wrap_set[prlc_pkg::BIT_ABORT_WRAP] = ext_wrap.abort_wrap;
    wrap_set[prlc_pkg::BIT_CRC_WRAP]   = ext_wrap.crc_err_wrap;
  end

  // Register read mux, status update and interrupt gating
  always_comb
  begin
    next_state = state;
    next_state.rvalid = rd_hit;
    if (rd_hit)
    begin
      case (req.addr)
        prlc_pkg::ADDR_UNDER_LOW:
          next_state.rdata = under_wide[prlc_pkg::UNDER_LOW_WIDTH-1:0];
        prlc_pkg::ADDR_UNDER_HIGH:
          next_state.rdata = {{(16-prlc_pkg::UNDER_HIGH_WIDTH){1'b0}},
            under_wide[prlc_pkg::UNDER_WIDTH-1:
                       prlc_pkg::UNDER_LOW_WIDTH]};
        prlc_pkg::ADDR_OVER:
          next_state.rdata = 16'(over_snapshot);
        prlc_pkg::ADDR_INT_STATUS:
          next_state.rdata = state.status;
        prlc_pkg::ADDR_INT_ENABLE:
          next_state.rdata = state.enable;
        default:
          next_state.rdata = prlc_pkg::ZERO16;
      endcase
    end
    // Read clears, but a fresh wrap in the same cycle survives
    if (rd_hit && req.addr == prlc_pkg::ADDR_INT_STATUS)
      next_state.status = wrap_set;
    else
      next_state.status = state.status | wrap_set;
    if (wr_hit && req.addr == prlc_pkg::ADDR_INT_ENABLE)
      next_state.enable = req.wdata & prlc_pkg::WRAP_MASK;
    // Irq follows the updated status so it drops with the clearing read
    next_state.irq = |(next_state.status & state.enable);
  end

  // Register the state; all flags reset to zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign rdata  = state.rdata;
  assign rvalid = state.rvalid;
  assign irq    = state.irq;

endmodule : prlc_top
`default_nettype wire

// File: prlc_sva.sv
// Checker for the length error counter bank
`timescale 1ns/1ps
`default_nettype none
module prlc_sva (
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire prlc_pkg::prlc_req_s      req,
  input wire prlc_pkg::prlc_frame_s    frame,
  input wire prlc_pkg::prlc_ext_wrap_s ext_wrap,
  input wire logic [15:0]              rdata,
  input wire logic                     rvalid,
  input wire logic                     irq
);
  logic [15:0] en;
  logic        rd;
  assign rd = req.cs && req.rd;
  // Shadow enable, so masking can be judged
  always_ff @(posedge clk)
    if (sys_rst)
      en <= 16'h0000;
    else if (req.cs && req.wr && req.addr == 8'h70)
      en <= req.wdata & prlc_pkg::WRAP_MASK;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read without rvalid");
  chk_no_stray: assert property (!rd |=> !rvalid && $stable(rdata))
    else $error("output moved without read");
  chk_reset_zero: assert property ($past(sys_rst) |-> !irq && rdata == 0)
    else $error("outputs not zero after reset");
  chk_wrap_irq: assert property ((ext_wrap & en[12:9]) != 0 |=> irq)
    else $error("enabled wrap gave no irq");
  chk_irq_masked: assert property (en == 0 |=> !irq)
    else $error("irq with all enables off");
  chk_read_clears: assert property (rd && req.addr == 8'h6f && ext_wrap == 0
    && !$past(frame.valid) |=> !irq)
    else $error("status read left irq up");
  chk_enable_read: assert property (rd && req.addr == 8'h70 |=> rdata == $past(en))
    else $error("enable readback wrong");
  chk_unmapped_zero: assert property (rd && req.addr < 8'h6c |=> rdata == 0)
    else $error("unmapped read not zero");
  cover property (rd && req.addr == 8'h6f && irq);
  cover property (ext_wrap != 0);
  cover property (req.cs && req.wr && req.addr == 8'h6d);
endmodule : prlc_sva
bind prlc_top prlc_sva u_sva (.clk, .sys_rst, .req, .frame, .ext_wrap,
  .rdata, .rvalid, .irq);
`default_nettype wire

// File: prlc_top_tb.sv
// Self-checking bench for the length error counter bank
`timescale 1ns/1ps
`default_nettype none
module prlc_top_tb;
  logic                     clk, sys_rst, irq, rvalid, dis;
  prlc_pkg::prlc_req_s      req;
  prlc_pkg::prlc_frame_s    frame;
  prlc_pkg::prlc_ext_wrap_s ext_wrap, ew;
  logic [15:0]              rdata, min_len, max_len;
  int                       err_count, comparisons;
  // Narrow counters so wraps come quickly
  prlc_top #(.UNDER_WIDTH(3), .OVER_WIDTH(3)) dut (.clk, .sys_rst, .req,
    .frame, .min_packet_length(min_len), .max_packet_length(max_len),
    .undersize_discard_enable(dis), .oversize_discard_enable(dis),
    .ext_wrap, .rdata, .rvalid, .irq);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a);
    @(negedge clk);
    req = '{1'b1, 1'b1, 1'b0, a, 16'hffff};
    @(negedge clk);
    req = '0;
  endtask : wr
  // Read; any pending wrap pulse lands in the read cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    req = '{1'b1, 1'b0, 1'b1, a, 16'h0000};
    ext_wrap = ew;
    @(negedge clk);
    req = '0;
    ext_wrap = '0;
    ew = '0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, exp);
  endtask : rd
  task automatic send(input logic [15:0] len, input int n);
    repeat (n)
    begin
      @(negedge clk);
      frame = '{1'b1, len};
    end
    @(negedge clk);
    frame = '0;
    repeat (3) @(negedge clk);
  endtask : send
  task automatic give_verdict;
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // Whole run is about 140 cycles
  initial
  begin
    #200us;
    err_count++;
    give_verdict();
  end
  initial
  begin
    sys_rst = 1;
    req = '0;
    frame = '0;
    ext_wrap = '0;
    ew = '0;
    dis = 0;
    min_len = 16'h0040;
    max_len = 16'h05dc;
    repeat (4) @(posedge clk);
    @(negedge clk);
    sys_rst = 0;
    for (int i = 0; i < 5; i++) rd(8'(8'h6c + i), 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h70);
    rd(8'h70, 16'h7e00);
    send(16'h003f, 5);
    dis = 1;
    send(16'h0040, 1);
    send(16'h05dc, 1);
    wr(8'h6d);
    rd(8'h6c, 16'h0005);
    rd(8'h6d, 16'h0000);
    wr(8'h6d);
    rd(8'h6c, 16'h0000);
    send(16'h05dd, 6);
    wr(8'h6e);
    rd(8'h6e, 16'h0006);
    // Discard enabled must not stop counting
    send(16'h003f, 9);
    send(16'h05dd, 8);
    chk({15'h0000, irq}, 16'h0001);
    rd(8'h6f, 16'h6000);
    rd(8'h6f, 16'h0000);
    wr(8'h6d);
    rd(8'h6c, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      ew = prlc_pkg::prlc_ext_wrap_s'(4'h8 >> i);
      rd(8'h6f, 16'h0000);
      rd(8'h6f, 16'h1000 >> i);
    end
    // Moved length limits must move the counting thresholds
    min_len = 16'h0020;
    max_len = 16'h0030;
    send(16'h003f, 1);
    send(16'h001f, 2);
    wr(8'h6d);
    rd(8'h6c, 16'h0002);
    wr(8'h6e);
    rd(8'h6e, 16'h0001);
    wr(8'h72);
    rd(8'h70, 16'h7e00);
    give_verdict();
  end
endmodule : prlc_top_tb
`default_nettype wire
